// ===== adc_out_map.svh
`ifndef ADC_OUT_MAP_SVH
`define ADC_OUT_MAP_SVH
`define CODE_W 12
`define CODE_MAX 12'hfff
`define CODE_ZERO 12'h000
`define POS_W 18
`define AIN_W 16
`define BIPOLAR_OFFSET 18'sh02000
`define STEP_FINE 18'sh00002
`define STEP_COARSE 18'sh00004
`define HALF_FINE 18'sh00001
`define HALF_COARSE 18'sh00002
`define SYS_CLK_PERIOD_NS 50
`define MIN_PHASE_NS 167
`define MIN_PHASE_CYC ((`MIN_PHASE_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
`define MIN_CLK_FREQ_KHZ 20
`define MAX_PERIOD_CYC (1000000 / (`MIN_CLK_FREQ_KHZ * `SYS_CLK_PERIOD_NS))
`define PHASE_CNT_W 11
`define STAGES 3
`define RANGE_SEL_UNI_LOW 2'h0
`define RANGE_SEL_UNI_HIGH 2'h1
`define RANGE_SEL_BIPOLAR 2'h2
`endif

// ===== adc_out_pkg.sv
package adc_out_pkg;
	`include "adc_out_map.svh"
	typedef enum logic [1:0] {RANGE_UNI_LOW, RANGE_UNI_HIGH, RANGE_BIPOLAR} range_t;
	typedef logic [`CODE_W-1:0] code_t;
	typedef logic signed [`POS_W-1:0] pos_t;
endpackage : adc_out_pkg

// ===== adc_output_stage.sv
`timescale 1ns/1ps
module adc_output_stage
	import adc_out_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic convClk,
	input wire logic signed [`AIN_W-1:0] ain,
	input wire logic [1:0] rangeSel,
	input wire logic refChange,
	output code_t dataOut,
	output logic out_of_range_flag,
	output logic top_output_bit,
	output logic resultValid,
	output logic dataStrobe,
	output logic phaseFault,
	output logic clockStalled
);
	typedef struct packed {
		logic convClkPrev;
		logic signed [`AIN_W-1:0] held;
		code_t [`STAGES-1:0] code;
		logic [`STAGES-1:0] flag;
		logic [`STAGES-1:0] good;
		code_t dataOut;
		logic flagOut;
		logic validOut;
		logic strobe;
		logic [`PHASE_CNT_W-1:0] phaseCnt;
		logic phaseFault;
		logic clockStalled;
	} state_t;

	state_t cur_ff;
	state_t nxt_cur;
	code_t qCode;
	logic qFlag;
	range_t range;

	function automatic range_t decode_range(input logic [1:0] sel);
		range_t r;
		r = RANGE_UNI_LOW;
		if (sel == `RANGE_SEL_UNI_HIGH) begin
			r = RANGE_UNI_HIGH;
		end else if (sel == `RANGE_SEL_BIPOLAR) begin
			r = RANGE_BIPOLAR;
		end
		return r;
	endfunction : decode_range

	assign range = decode_range(rangeSel);

	adc_quantizer quant (
		.ain(cur_ff.held),
		.range(range),
		.code(qCode),
		.outOfRange(qFlag)
	);

	always_comb begin
		logic rise;
		logic fall;
		rise = 1'b0;
		fall = 1'b0;
		nxt_cur = cur_ff;
		rise = convClk & ~cur_ff.convClkPrev;
		fall = ~convClk & cur_ff.convClkPrev;
		nxt_cur.convClkPrev = convClk;
		nxt_cur.strobe = 1'b0;
		if (rise || fall) begin
			nxt_cur.phaseCnt = '0;
			if (cur_ff.phaseCnt < `PHASE_CNT_W'(`MIN_PHASE_CYC - 1)) begin
				nxt_cur.phaseFault = 1'b1;
			end else begin
				nxt_cur.phaseFault = 1'b0;
			end
			nxt_cur.clockStalled = 1'b0;
		end else if (cur_ff.phaseCnt < `PHASE_CNT_W'(`MAX_PERIOD_CYC)) begin
			nxt_cur.phaseCnt = cur_ff.phaseCnt + `PHASE_CNT_W'(1);
		end else begin
			nxt_cur.clockStalled = 1'b1;
		end
		if (rise) begin
			nxt_cur.held = ain;
			nxt_cur.code[2] = cur_ff.code[1];
			nxt_cur.flag[2] = cur_ff.flag[1];
			nxt_cur.good[2] = cur_ff.good[1];
			nxt_cur.code[1] = cur_ff.code[0];
			nxt_cur.flag[1] = cur_ff.flag[0];
			nxt_cur.good[1] = cur_ff.good[0];
			nxt_cur.dataOut = cur_ff.code[2];
			nxt_cur.flagOut = cur_ff.flag[2];
			nxt_cur.validOut = cur_ff.good[2];
			nxt_cur.strobe = 1'b1;
		end
		if (fall) begin
			nxt_cur.code[0] = qCode;
			nxt_cur.flag[0] = qFlag;
			nxt_cur.good[0] = 1'b1;
		end
		if (refChange) begin
			nxt_cur.good = '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign dataOut = cur_ff.dataOut;
	assign out_of_range_flag = cur_ff.flagOut;
	assign top_output_bit = cur_ff.dataOut[`CODE_W-1];
	assign resultValid = cur_ff.validOut;
	assign dataStrobe = cur_ff.strobe;
	assign phaseFault = cur_ff.phaseFault;
	assign clockStalled = cur_ff.clockStalled;
endmodule : adc_output_stage

// ===== adc_output_stage_chk.sv
`timescale 1ns/1ps
module adc_output_stage_chk
	import adc_out_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic convClk,
	input wire code_t dataOut,
	input wire logic out_of_range_flag,
	input wire logic top_output_bit,
	input wire logic resultValid,
	input wire logic dataStrobe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	sequence pulse;
		dataStrobe ##1 !dataStrobe;
	endsequence
	top_bit_a: assert property (top_output_bit == dataOut[11]) else $error("top");
	strobe_len_a: assert property ($rose(dataStrobe) |-> pulse) else $error("len");
	strobe_edge_a: assert property (dataStrobe |-> $past(convClk) && !$past(convClk, 2)) else $error("edge");
	data_hold_a: assert property (!dataStrobe && $past(nrst) |-> $stable(dataOut)) else $error("data");
	flag_hold_a: assert property (!dataStrobe && $past(nrst) |-> $stable(out_of_range_flag)) else $error("flag");
	valid_rise_a: assert property ($rose(resultValid) |-> dataStrobe) else $error("valid");
	under_code_a: assert property (out_of_range_flag && !top_output_bit |-> dataOut == 12'h000) else $error("u");
	over_code_a: assert property (out_of_range_flag && top_output_bit |-> dataOut == 12'hfff) else $error("o");
endmodule : adc_output_stage_chk
bind adc_output_stage adc_output_stage_chk chk (.clk_sys, .nrst, .convClk, .dataOut, .out_of_range_flag,
	.top_output_bit, .resultValid, .dataStrobe);

// ===== adc_quantizer.sv
`timescale 1ns/1ps
module adc_quantizer
	import adc_out_pkg::*;
(
	input wire logic signed [`AIN_W-1:0] ain,
	input wire range_t range,
	output code_t code,
	output logic outOfRange
);
	pos_t pos;
	pos_t step;
	pos_t half;
	pos_t top;
	pos_t quot;
	always_comb begin
		// Position above the low end of the range, in fine half-step units
		pos = pos_t'(ain);
		step = `STEP_COARSE;
		half = `HALF_COARSE;
		unique case (range)
			RANGE_UNI_LOW: begin
				step = `STEP_FINE;
				half = `HALF_FINE;
			end
			RANGE_UNI_HIGH: begin
			end
			RANGE_BIPOLAR: begin
				pos = pos_t'(ain) + `BIPOLAR_OFFSET;
			end
		endcase
		top = pos_t'({6'h00, `CODE_MAX}) * step;
		quot = (pos + half) / step;
		code = quot[`CODE_W-1:0];
		outOfRange = 1'b0;
		if (pos < -half) begin
			code = `CODE_ZERO;
			outOfRange = 1'b1;
		end else if (pos > top + half) begin
			code = `CODE_MAX;
			outOfRange = 1'b1;
		end else if (pos + half >= top + step) begin
			code = `CODE_MAX;
		end
	end
endmodule : adc_quantizer

// ===== host_capture.sv
`timescale 1ns/1ps
module host_capture
	import adc_out_pkg::*;
(
	input wire logic clk_sys,
	input wire logic dataStrobe,
	input wire code_t dataOut,
	input wire logic out_of_range_flag,
	output code_t twos,
	output logic under,
	output logic over
);
	always_ff @(posedge clk_sys) begin
		if (dataStrobe) begin
			twos <= {~dataOut[11], dataOut[10:0]};
			under <= out_of_range_flag & ~dataOut[11];
			over <= out_of_range_flag & dataOut[11];
		end
	end
endmodule : host_capture

// ===== tb.sv
`timescale 1ns/1ps
module tb;
	import adc_out_pkg::*;
	logic clk_sys = 1'h0, nrst = 1'h0, convClk = 1'h0, refChange = 1'h0, flag, valid, strobe, under, over;
	logic fault, stalled;
	logic signed [15:0] ain = 16'h0000;
	logic [1:0] rangeSel = 2'h0;
	code_t dataOut, twos;
	int miscompares = 0, comparisons = 0, cyc = 0;
	always #25 clk_sys = ~clk_sys;
	adc_output_stage dut (.clk_sys, .nrst, .convClk, .ain, .rangeSel, .refChange, .dataOut, .out_of_range_flag(flag),
		.top_output_bit(), .resultValid(valid), .dataStrobe(strobe), .phaseFault(fault), .clockStalled(stalled));
	host_capture hc (.clk_sys, .dataStrobe(strobe), .dataOut, .out_of_range_flag(flag), .twos, .under, .over);
	task chk(input string n, input logic [11:0] s, e);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task per;
		convClk = 1'h1;
		repeat (4) @(negedge clk_sys);
		convClk = 1'h0;
		repeat (4) @(negedge clk_sys);
	endtask : per
	task conv(input logic signed [15:0] a, input logic [1:0] r, input code_t c, input logic f);
		ain = a;
		rangeSel = r;
		repeat (4) per();
		chk("data", dataOut, c);
		chk("flag", flag, f);
		chk("under", under, f & ~c[11]);
		chk("over", over, f & c[11]);
	endtask : conv
	task t_codes;
		conv(16'sd0, 2'h0, 12'h000, 1'h0);
		conv(16'sd8190, 2'h0, 12'hfff, 1'h0);
		conv(16'sd8192, 2'h1, 12'h800, 1'h0);
		conv(16'sd16380, 2'h1, 12'hfff, 1'h0);
		conv(16'sd0, 2'h2, 12'h800, 1'h0);
		chk("twos", twos, 12'h000);
		conv(-16'sd8192, 2'h2, 12'h000, 1'h0);
		conv(-16'sd9000, 2'h2, 12'h000, 1'h1);
		$display("codes done");
	endtask : t_codes
	task t_flag;
		conv(-16'sd10, 2'h0, 12'h000, 1'h1);
		conv(16'sd8200, 2'h0, 12'hfff, 1'h1);
		ain = 16'sd100;
		for (int i = 0; i < 4; i++) begin
			per();
			chk("hold", flag, i < 3);
		end
		$display("flag done");
	endtask : t_flag
	task t_ref;
		refChange = 1'h1;
		@(negedge clk_sys);
		refChange = 1'h0;
		for (int i = 0; i < 4; i++) begin
			per();
			chk("valid", valid, i == 3);
		end
		$display("ref done");
	endtask : t_ref
	task t_clk;
		per();
		chk("phase ok", fault, 1'h0);
		convClk = 1'h1;
		repeat (2) @(negedge clk_sys);
		convClk = 1'h0;
		repeat (2) @(negedge clk_sys);
		chk("phase short", fault, 1'h1);
		repeat (1010) @(negedge clk_sys);
		chk("stall", stalled, 1'h1);
		per();
		chk("stall clear", stalled, 1'h0);
		chk("phase clear", fault, 1'h0);
		$display("clock done");
	endtask : t_clk
	task end_sim;
		$display("checks %0d fails %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			end_sim();
		end
	end
	initial begin
		repeat (16) @(negedge clk_sys);
		nrst = 1'h1;
		t_codes();
		t_flag();
		t_ref();
		t_clk();
		end_sim();
	end
endmodule : tb
